// File: shared/cdp_pkg.sv
// ==========================================
// register map
package cdp_pkg;
  localparam logic [7:0] SFR_SPACE_BASE = 8'h80;
  localparam logic [7:0] SP_ADDR        = 8'h81;
  localparam logic [7:0] DPL_ADDR       = 8'h82;
  localparam logic [7:0] DPH_ADDR       = 8'h83;
  localparam logic [7:0] AUX1_ADDR      = 8'ha2;
  localparam logic [7:0] PSW_ADDR       = 8'hd0;
  localparam logic [7:0] B_ADDR         = 8'hf0;
  localparam logic [7:0] SP_RST         = 8'h07;
  localparam logic [7:0] DP_RST         = 8'h00;
  localparam logic [7:0] AUX1_RST       = 8'h00;
  localparam logic [7:0] PSW_RST        = 8'h00;
  localparam logic [7:0] B_RST          = 8'h00;
  localparam logic [7:0] AUX1_RW_MASK   = 8'hf1;
  // ==========================================
  // status word bit positions, plus the aux select bit
  localparam int unsigned CY_BIT  = 7;
  localparam int unsigned AC_BIT  = 6;
  localparam int unsigned F0_BIT  = 5;
  localparam int unsigned BSH_BIT = 4;
  localparam int unsigned BSL_BIT = 3;
  localparam int unsigned OV_BIT  = 2;
  localparam int unsigned F1_BIT  = 1;
  localparam int unsigned PAR_BIT = 0;
  localparam int unsigned SEL_BIT = 0;
  // ==========================================
  // memory sizes and timing
  localparam int unsigned IRAM_DEPTH = 256;
  localparam int unsigned EXPANDED_RAM_DEPTH = 1024;
  localparam int unsigned PAGE_DEPTH = 256;
  localparam logic [2:0]  CYC_MIN    = 3'h1;
  localparam logic [2:0]  CYC_MAX    = 3'h7;
  // ==========================================
  // commands from the core sequencer
  typedef enum logic [4:0] {
    OP_NONE, OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR,
    OP_REG_RD, OP_REG_WR, OP_PTR_INC, OP_PTR_LOAD,
    OP_CODE_PTR, OP_CODE_PC, OP_JMP_PTR, OP_XPTR_RD,
    OP_XPTR_WR, OP_XRI_RD, OP_XRI_WR, OP_BIT_AND,
    OP_BIT_OR, OP_BIT_MOV, OP_BIT_CPL, OP_FLAGS
  } cdp_op_e;
  typedef struct packed {
    cdp_op_e     op;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [15:0] word;
    logic [2:0]  reg_num;
    logic        use_sp;
    logic        bit_val;
    logic [2:0]  cycles;
  } cdp_cmd_s;
  typedef struct packed {
    logic        done;
    logic        sfr_miss;
    logic        off_chip;
    logic [7:0]  data;
    logic [15:0] addr;
  } cdp_rsp_s;
endpackage : cdp_pkg

// File: hdl/cdp_core_regs.sv
// Notes on behaviour
// RL1: status word bits 7..0: carry, aux carry, flag0, bank hi, bank lo, ovf, flag1, parity.
// RL2: parity bit is odd parity of accumulator, tracked every enabled cycle.
// RL3: two bank-select bits choose one of four working-register banks.
// RL4: register form uses 3-bit number inside the selected bank.
// RL5: carry bit doubles as the Boolean bit accumulator.
// RL6: direct addressing reaches only internal RAM and special registers.
// RL7: 8-bit indirect address comes from reg 0/1 of bank or stack pointer.
// RL8: 16-bit indirect address comes only from the selected data pointer.
// RL9: indexed code reads use pointer or program counter plus accumulator.
// RL10: indirect jump target is selected pointer plus accumulator.
// RL11: each instruction takes 1 to 7 plain clock cycles.
// RL12: two independent 16-bit pointers, chosen by a select bit.
// RL13: select bit 0 of aux control picks pointer 0/1, resets to 0.
// RL14: increment, load, code read, external read/write, jump use selected pointer.
// RL15: increment adds one across all 16 bits of the selected pointer.
// RL16: software adds a no-op when switching on/off-chip expanded RAM.
// RL17: 1024 bytes of on-chip expanded RAM through pointer external moves.
// RL18: 256-byte paged space via indirect external moves shares low expanded RAM.
// RL19: special registers only direct addressed, never indirect.
// RL20: lowest 32 internal RAM bytes form four banks of eight registers.
// RL21: direct above 7FH hits special registers, indirect hits upper RAM.
// RL22: pointer low/high byte registers access the selected pointer.
`timescale 1ns/1ns
module cdp_core_regs import cdp_pkg::*; #(
  parameter int unsigned EXPANDED_RAM_BYTES = EXPANDED_RAM_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cmd_valid_i,
  input  wire cdp_cmd_s    cmd_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [15:0] pc_i,
  output logic             cmd_ready_o,
  output cdp_rsp_s         rsp_o,
  output logic [7:0]       psw_o,
  output logic [7:0]       sp_o,
  output logic [7:0]       b_o,
  output logic [7:0]       aux1_o,
  output logic [15:0]      pointer_zero_o,
  output logic [15:0]      pointer_one_o
);
  localparam int unsigned XA = $clog2(EXPANDED_RAM_BYTES);

  // ==========================================
  // storage
  logic [7:0]  iram [IRAM_DEPTH];
  logic [7:0]  expanded_ram [EXPANDED_RAM_BYTES];
  logic [7:0]  program_status_word;
  logic [7:0]  sp;
  logic [7:0]  b_reg;
  logic [7:0]  aux1;
  logic [15:0] ptr [2];
  logic        busy;
  logic        ready;
  logic [2:0]  cnt;
  cdp_rsp_s    rsp;
  logic [7:0]  next_psw;
  cdp_rsp_s    next_rsp;
  logic [7:0]  sfr_rdata;

  // true for the special registers this block owns
  function automatic logic own_sfr(input logic [7:0] a);
    own_sfr = (a == SP_ADDR) || (a == DPL_ADDR) || (a == DPH_ADDR) ||
              (a == AUX1_ADDR) || (a == PSW_ADDR) || (a == B_ADDR);
  endfunction : own_sfr

  // ==========================================
  // address formation
  wire cdp_op_e     op       = cmd_i.op;
  // ready stays low one cycle after reset while busy is already clear, so a
  // command shown then is still taken; callers should wait for ready anyway
  wire logic        go       = ce_i & cmd_valid_i & ~busy;
  wire logic [1:0]  bank     = {program_status_word[BSH_BIT], program_status_word[BSL_BIT]}; // RL3
  wire logic        sel      = aux1[SEL_BIT]; // RL13
  wire logic [15:0] cur_ptr  = ptr[sel]; // RL12
  // bank base is bank*8, so registers live in the lowest 32 bytes
  wire logic [7:0]  reg_addr = {3'h0, bank, cmd_i.reg_num}; // RL4 RL20
  wire logic [7:0]  ri_addr  = {3'h0, bank, 2'h0, cmd_i.reg_num[0]}; // RL7
  wire logic [7:0]  ri_val   = iram[ri_addr];
  wire logic [7:0]  ind_addr = cmd_i.use_sp ? sp : ri_val; // RL7
  // direct above 7fh is the special space; indirect never is
  wire logic        dir_sfr  = cmd_i.addr >= SFR_SPACE_BASE; // RL6 RL21
  wire logic        sfr_own  = own_sfr(cmd_i.addr);

  // indexed table reads and the indirect jump share one adder
  wire logic        use_pc   = op == OP_CODE_PC;
  wire logic [15:0] idx_base = use_pc ? pc_i : cur_ptr; // RL9
  wire logic [15:0] idx_sum  = idx_base + {8'h00, acc_i}; // RL9 RL10

  // expanded ram: pointer moves above the on-chip range go off chip
  // an off-chip pointer write stores nothing here and is flagged in the response
  wire logic        ptr_on   = cur_ptr < 16'(EXPANDED_RAM_BYTES); // RL17
  wire logic [XA-1:0] xp_idx = cur_ptr[XA-1:0]; // RL8
  // paged moves land in the low part of the same array
  wire logic [XA-1:0] xr_idx = {{(XA-8){1'b0}}, ri_val}; // RL18

  // ==========================================
  // write strobes
  wire logic dir_wr   = go & (op == OP_DIR_WR);
  wire logic sfr_wr   = dir_wr & dir_sfr;
  wire logic w_sp     = sfr_wr & (cmd_i.addr == SP_ADDR);
  wire logic w_dpl    = sfr_wr & (cmd_i.addr == DPL_ADDR);
  wire logic w_dph    = sfr_wr & (cmd_i.addr == DPH_ADDR);
  wire logic w_aux1   = sfr_wr & (cmd_i.addr == AUX1_ADDR);
  wire logic w_psw    = sfr_wr & (cmd_i.addr == PSW_ADDR);
  wire logic w_b      = sfr_wr & (cmd_i.addr == B_ADDR);
  wire logic p_inc    = go & (op == OP_PTR_INC);
  wire logic p_load   = go & (op == OP_PTR_LOAD);

  // indirect writes go to ram over the full 256 bytes
  wire logic iram_we  = go & ((op == OP_DIR_WR & ~dir_sfr) |
                              (op == OP_IND_WR) | (op == OP_REG_WR)); // RL19
  wire logic [7:0] iram_wa = (op == OP_DIR_WR) ? cmd_i.addr :
                             (op == OP_IND_WR) ? ind_addr : reg_addr;
  wire logic expanded_ram_we  = go & ((op == OP_XPTR_WR & ptr_on) |
                              (op == OP_XRI_WR));
  wire logic [XA-1:0] expanded_ram_wa = (op == OP_XRI_WR) ? xr_idx : xp_idx;

  // ==========================================
  // cycle count of the instruction, zero treated as one
  wire logic [2:0] cyc = (cmd_i.cycles < CYC_MIN) ? CYC_MIN :
                         (cmd_i.cycles > CYC_MAX) ? CYC_MAX : cmd_i.cycles;
  wire logic       one_cyc = cyc == CYC_MIN;

  // ==========================================
  // special register read mux
  // unowned special addresses read as zero and are flagged as a miss
  always_comb begin
    case (cmd_i.addr)
      SP_ADDR:   sfr_rdata = sp;
      DPL_ADDR:  sfr_rdata = cur_ptr[7:0]; // RL22
      DPH_ADDR:  sfr_rdata = cur_ptr[15:8]; // RL22
      AUX1_ADDR: sfr_rdata = aux1 & AUX1_RW_MASK;
      PSW_ADDR:  sfr_rdata = program_status_word;
      B_ADDR:    sfr_rdata = b_reg;
      default:   sfr_rdata = 8'h00;
    endcase
  end

  // ==========================================
  // status word next value
  // bit operations touch only the carry; the other flags except parity keep their value
  always_comb begin
    next_psw = program_status_word;
    if (w_psw) begin
      next_psw = cmd_i.data; // RL1
    end
    if (go) begin
      case (op)
        OP_BIT_AND: next_psw[CY_BIT] = program_status_word[CY_BIT] & cmd_i.bit_val; // RL5
        OP_BIT_OR:  next_psw[CY_BIT] = program_status_word[CY_BIT] | cmd_i.bit_val; // RL5
        OP_BIT_MOV: next_psw[CY_BIT] = cmd_i.bit_val; // RL5
        OP_BIT_CPL: next_psw[CY_BIT] = ~program_status_word[CY_BIT]; // RL5
        OP_FLAGS: begin
          next_psw[CY_BIT] = cmd_i.data[CY_BIT];
          next_psw[AC_BIT] = cmd_i.data[AC_BIT];
          next_psw[OV_BIT] = cmd_i.data[OV_BIT];
        end
        default: next_psw = next_psw;
      endcase
    end
    // parity is hardware owned; a software write cannot hold it
    next_psw[PAR_BIT] = ^acc_i; // RL2
  end

  // ==========================================
  // response formed and registered at accept, done raised at the last cycle
  // a write returns the old contents, which lets the core build an exchange
  always_comb begin
    next_rsp = '0;
    next_rsp.done = one_cyc;
    case (op)
      OP_DIR_RD, OP_DIR_WR: begin
        next_rsp.data = dir_sfr ? sfr_rdata : iram[cmd_i.addr]; // RL6
        next_rsp.sfr_miss = dir_sfr & ~sfr_own;
        next_rsp.addr = {8'h00, cmd_i.addr};
      end
      OP_IND_RD, OP_IND_WR: begin
        next_rsp.data = iram[ind_addr]; // RL19 RL21
        next_rsp.addr = {8'h00, ind_addr};
      end
      OP_REG_RD, OP_REG_WR: begin
        next_rsp.data = iram[reg_addr]; // RL4
        next_rsp.addr = {8'h00, reg_addr};
      end
      OP_CODE_PTR, OP_CODE_PC, OP_JMP_PTR: begin
        next_rsp.addr = idx_sum; // RL9 RL10 RL14
      end
      OP_XPTR_RD, OP_XPTR_WR: begin
        next_rsp.data = ptr_on ? expanded_ram[xp_idx] : 8'h00; // RL8 RL14
        next_rsp.off_chip = ~ptr_on;
        next_rsp.addr = cur_ptr;
      end
      OP_XRI_RD, OP_XRI_WR: begin
        next_rsp.data = expanded_ram[xr_idx]; // RL18
        next_rsp.addr = {8'h00, ri_val};
      end
      OP_PTR_INC, OP_PTR_LOAD: begin
        next_rsp.addr = cur_ptr;
      end
      default: next_rsp.data = 8'h00;
    endcase
  end

  // ==========================================
  // cpu registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_status_word   <= PSW_RST;
      sp    <= SP_RST;
      b_reg <= B_RST;
      aux1  <= AUX1_RST; // RL13
    end else if (ce_i) begin
      program_status_word <= next_psw;
      if (w_sp) begin
        sp <= cmd_i.data;
      end
      if (w_b) begin
        b_reg <= cmd_i.data;
      end
      if (w_aux1) begin
        aux1 <= cmd_i.data & AUX1_RW_MASK; // RL13
      end
    end
  end

  // ==========================================
  // dual data pointer; only the selected one ever changes
  // increment and load win over byte writes; the core never issues both at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr[0] <= {DP_RST, DP_RST};
      ptr[1] <= {DP_RST, DP_RST};
    end else if (ce_i) begin
      if (p_inc) begin
        ptr[sel] <= cur_ptr + 16'h0001; // RL14 RL15
      end else if (p_load) begin
        ptr[sel] <= cmd_i.word; // RL14
      end else if (w_dpl) begin
        ptr[sel][7:0] <= cmd_i.data; // RL22
      end else if (w_dph) begin
        ptr[sel][15:8] <= cmd_i.data; // RL22
      end
    end
  end

  // ==========================================
  // memories: async read keeps one-cycle ops, costs distributed ram
  // the arrays have no reset: contents are unknown until software writes them
  always_ff @(posedge clk_i) begin
    if (ce_i && iram_we) begin
      iram[iram_wa] <= cmd_i.data;
    end
    if (ce_i && expanded_ram_we) begin
      expanded_ram[expanded_ram_wa] <= cmd_i.data; // RL17 RL18
    end
  end

  // ==========================================
  // instruction cycle counter and response register
  // ready drops for the rest of a multi-cycle instruction and rises together with done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy  <= 1'b0;
      ready <= 1'b0;
      cnt   <= 3'h0;
      rsp   <= '0;
    end else if (ce_i) begin
      ready    <= 1'b1;
      rsp.done <= 1'b0;
      if (go) begin
        rsp <= next_rsp;
        if (!one_cyc) begin
          busy  <= 1'b1; // RL11
          ready <= 1'b0;
          cnt   <= cyc - 3'h1;
        end
      end else if (busy) begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1) begin
          busy     <= 1'b0;
          rsp.done <= 1'b1; // RL11
        end else begin
          ready <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // outputs, all straight from flops
  assign cmd_ready_o    = ready;
  assign rsp_o          = rsp;
  assign psw_o          = program_status_word;
  assign sp_o           = sp;
  assign b_o            = b_reg;
  assign aux1_o         = aux1;
  assign pointer_zero_o = ptr[0];
  assign pointer_one_o  = ptr[1];
endmodule : cdp_core_regs

// File: verif/cdp_core_regs_props.sv
`timescale 1ns/1ns
// ==========
// port checker
module cdp_core_regs_props import cdp_pkg::*; #(
  parameter int unsigned EXPANDED_RAM_BYTES = EXPANDED_RAM_DEPTH
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cmd_valid_i,
  input wire cdp_cmd_s    cmd_i,
  input wire logic [7:0]  acc_i,
  input wire logic [15:0] pc_i,
  input wire logic        cmd_ready_o,
  input wire cdp_rsp_s    rsp_o,
  input wire logic [7:0]  psw_o,
  input wire logic [7:0]  sp_o,
  input wire logic [7:0]  b_o,
  input wire logic [7:0]  aux1_o,
  input wire logic [15:0] pointer_zero_o,
  input wire logic [15:0] pointer_one_o
);
  // a command counts only when enable, valid and ready agree
  wire take = ce_i && cmd_valid_i && cmd_ready_o;
  wire sel  = aux1_o[SEL_BIT];
  wire dwr  = take && cmd_i.op == OP_DIR_WR;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_par; ce_i |=> psw_o[PAR_BIT] == $past(^acc_i); endproperty
  a_par: assert property (p_par) else $error("parity off");
  property p_aux; aux1_o[3:1] == 3'h0; endproperty
  a_aux: assert property (p_aux) else $error("aux reserved set");
  property p_inc;
    take && cmd_i.op == OP_PTR_INC && !sel |=>
      pointer_zero_o == $past(pointer_zero_o) + 16'h1 && $stable(pointer_one_o);
  endproperty
  a_inc: assert property (p_inc) else $error("inc wrong");
  property p_load;
    take && cmd_i.op == OP_PTR_LOAD |=> (sel ? pointer_one_o : pointer_zero_o) == $past(cmd_i.word);
  endproperty
  a_load: assert property (p_load) else $error("load wrong");
  property p_jmp;
    take && cmd_i.op == OP_JMP_PTR |=>
      rsp_o.addr == $past(sel ? pointer_one_o : pointer_zero_o) + {8'h0, $past(acc_i)};
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump target");
  property p_pc;
    take && cmd_i.op == OP_CODE_PC |=> rsp_o.addr == $past(pc_i) + {8'h0, $past(acc_i)};
  endproperty
  a_pc: assert property (p_pc) else $error("pc index");
  property p_psw; dwr && cmd_i.addr == PSW_ADDR |=> psw_o[7:1] == $past(cmd_i.data[7:1]);
  endproperty
  a_psw: assert property (p_psw) else $error("psw write");
  property p_sp; dwr && cmd_i.addr == SP_ADDR |=> sp_o == $past(cmd_i.data); endproperty
  a_sp: assert property (p_sp) else $error("sp write");
  property p_cyc;
    take && cmd_i.cycles == 3'h3 |=> !cmd_ready_o [*2] ##1 (rsp_o.done && cmd_ready_o);
  endproperty
  a_cyc: assert property (p_cyc) else $error("cycle count");
  c_inc: cover property (take && cmd_i.op == OP_PTR_INC);
  c_cyc: cover property (take && cmd_i.cycles == 3'h3);
  c_jmp: cover property (take && cmd_i.op == OP_JMP_PTR);
endmodule : cdp_core_regs_props
bind cdp_core_regs cdp_core_regs_props #(.EXPANDED_RAM_BYTES(EXPANDED_RAM_BYTES)) u_cdp_core_regs_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .acc_i(acc_i), .pc_i(pc_i), .cmd_ready_o(cmd_ready_o), .rsp_o(rsp_o), .psw_o(psw_o),
  .sp_o(sp_o), .b_o(b_o), .aux1_o(aux1_o), .pointer_zero_o(pointer_zero_o),
  .pointer_one_o(pointer_one_o));

// File: verif/cdp_core_regs_test.sv
`timescale 1ns/1ns
module cdp_core_regs_test import cdp_pkg::*; ;
  logic        clk_i, rst_i, ce_i, valid, ready;
  cdp_cmd_s    cmd;
  cdp_rsp_s    rsp;
  logic [7:0]  acc, program_status_word, sp, b, aux;
  logic [15:0] pc, p0, p1;
  int          fails, n_checks, lat;
  cdp_core_regs #(.EXPANDED_RAM_BYTES(1024)) u_cdp_core_regs (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_valid_i(valid), .cmd_i(cmd),
    .acc_i(acc), .pc_i(pc), .cmd_ready_o(ready), .rsp_o(rsp), .psw_o(program_status_word), .sp_o(sp),
    .b_o(b), .aux1_o(aux), .pointer_zero_o(p0), .pointer_one_o(p1));
  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // valid holds until a ready edge; one idle edge after so valid never toggles twice
  task automatic go(input cdp_op_e op, input logic [7:0] a, input logic [7:0] d,
                    input logic [15:0] w = 16'h0, input logic [2:0] c = 3'h1);
    // address bit 7 selects the stack pointer for indirect moves, data bit 0 the bit operand
    cmd = '{op: op, addr: a, data: d, word: w, reg_num: a[2:0], use_sp: a[7], bit_val: d[0],
            cycles: c};
    valid = 1'b1;
    do @(posedge clk_i); while (ready !== 1'b1);
    #1 valid = 1'b0;
    lat = 0;
    while (rsp.done !== 1'b1 && lat < 20) begin
      @(posedge clk_i);
      #1 lat++;
    end
    // a done that never comes is a mismatch, not a silent pass
    if (lat >= 20) fails++;
    @(posedge clk_i);
    #1;
  endtask : go
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // ==========
  // scenarios
  task automatic t_regs;
    chk("reset", {sp, program_status_word}, {SP_RST, PSW_RST});
    chk("reset aux", {aux, b}, {AUX1_RST, B_RST});
    chk("reset dp", p0 | p1, 16'h0);
    go(OP_DIR_WR, AUX1_ADDR, 8'hff);
    chk("aux", aux, 8'hf1);
    go(OP_DIR_WR, DPL_ADDR, 8'h34);
    go(OP_DIR_WR, DPH_ADDR, 8'h12);
    chk("p1", p1, 16'h1234);
    chk("p0", p0, 16'h0);
    go(OP_DIR_RD, DPL_ADDR, 8'h0);
    chk("dpl", rsp.data, 8'h34);
    go(OP_DIR_WR, SP_ADDR, 8'h55);
    go(OP_DIR_WR, B_ADDR, 8'ha5);
    chk("sp b", {sp, b}, 16'h55a5);
    go(OP_DIR_WR, PSW_ADDR, 8'hff);
    chk("psw", program_status_word, 8'hfe);
    go(OP_DIR_WR, 8'h85, 8'h99);
    chk("miss", rsp.sfr_miss, 1'b1);
  endtask : t_regs
  // bank 3 first, then bank 0 for register and indirect access
  task automatic t_bank;
    go(OP_REG_WR, 8'h2, 8'h77);
    go(OP_DIR_RD, 8'h1a, 8'h0);
    chk("bank3", rsp.data, 8'h77);
    go(OP_DIR_WR, PSW_ADDR, 8'h00);
    go(OP_DIR_WR, 8'h02, 8'h11);
    go(OP_REG_RD, 8'h2, 8'h0);
    chk("bank0", rsp.data, 8'h11);
    go(OP_DIR_WR, 8'h00, 8'h90);
    go(OP_IND_WR, 8'h0, 8'h3c);
    go(OP_IND_RD, 8'h0, 8'h0);
    chk("upper", rsp.data, 8'h3c);
  endtask : t_bank
  task automatic t_ptr;
    go(OP_DIR_WR, AUX1_ADDR, 8'h00);
    go(OP_PTR_LOAD, 8'h0, 8'h0, 16'h12ff);
    go(OP_PTR_INC, 8'h0, 8'h0);
    chk("inc", p0, 16'h1300);
    chk("other", p1, 16'h1234);
    acc = 8'h10;
    go(OP_JMP_PTR, 8'h0, 8'h0);
    chk("jmp", rsp.addr, 16'h1310);
    pc = 16'hfff8;
    go(OP_CODE_PC, 8'h0, 8'h0);
    chk("pc", rsp.addr, 16'h0008);
    go(OP_PTR_LOAD, 8'h0, 8'h0, 16'hffff);
    go(OP_PTR_INC, 8'h0, 8'h0);
    chk("wrap", p0, 16'h0);
  endtask : t_ptr
  task automatic t_expanded_ram;
    go(OP_PTR_LOAD, 8'h0, 8'h0, 16'h0090);
    go(OP_XPTR_WR, 8'h0, 8'h6b, 16'h0, 3'h2);
    go(OP_XPTR_RD, 8'h0, 8'h0, 16'h0, 3'h3);
    chk("expanded_ram", rsp.data, 8'h6b);
    chk("lat3", 16'(lat), 16'h2);
    go(OP_XRI_RD, 8'h0, 8'h0, 16'h0, 3'h7);
    chk("paged", rsp.data, 8'h6b);
    chk("lat7", 16'(lat), 16'h6);
    go(OP_PTR_LOAD, 8'h0, 8'h0, 16'h0400);
    go(OP_NONE, 8'h0, 8'h0);
    go(OP_XPTR_WR, 8'h0, 8'h01);
    chk("off", rsp.off_chip, 1'b1);
  endtask : t_expanded_ram
  // carry as bit accumulator, flag load, stack-pointer indirect, paged write
  task automatic t_bits;
    go(OP_BIT_MOV, 8'h0, 8'h01);
    chk("mov c", program_status_word[CY_BIT], 1'b1);
    go(OP_BIT_AND, 8'h0, 8'h00);
    chk("and c", program_status_word[CY_BIT], 1'b0);
    go(OP_BIT_OR, 8'h0, 8'h01);
    chk("or c", program_status_word[CY_BIT], 1'b1);
    go(OP_BIT_CPL, 8'h0, 8'h00);
    chk("cpl c", program_status_word[CY_BIT], 1'b0);
    go(OP_FLAGS, 8'h0, 8'hc4);
    chk("flags", program_status_word, 8'hc5);
    go(OP_CODE_PTR, 8'h0, 8'h0);
    chk("code", rsp.addr, 16'h0410);
    go(OP_IND_WR, 8'h80, 8'h5a);
    go(OP_DIR_RD, 8'h55, 8'h0);
    chk("sp ind", rsp.data, 8'h5a);
    go(OP_NONE, 8'h0, 8'h0);
    go(OP_XRI_WR, 8'h0, 8'h3e);
    go(OP_PTR_LOAD, 8'h0, 8'h0, 16'h0090);
    go(OP_XPTR_RD, 8'h0, 8'h0);
    chk("paged wr", rsp.data, 8'h3e);
  endtask : t_bits
  // parity follows acc only while enabled
  task automatic t_par;
    acc = 8'h07;
    repeat (2) @(posedge clk_i);
    #1 chk("par1", program_status_word[PAR_BIT], 1'b1);
    ce_i = 1'b0;
    acc = 8'h03;
    repeat (2) @(posedge clk_i);
    #1 chk("frozen", program_status_word[PAR_BIT], 1'b1);
    ce_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("par0", program_status_word[PAR_BIT], 1'b0);
  endtask : t_par
  // ==========
  // clock, sequence, watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    valid = 1'b0;
    cmd = '0;
    acc = 8'h0;
    pc = 16'h0;
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    @(posedge clk_i);
    #1 t_regs();
    t_bank();
    t_ptr();
    t_expanded_ram();
    t_bits();
    t_par();
    give_verdict();
  end
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule : cdp_core_regs_test
